// file: logic/fifo_serial_interface.v
// asynchronous serial interface with sixteen-entry transmit and receive
// fifos, overrun flag, frame format and clock source selection
// assumes all inputs synchronous to i_ref_clk; registers on a plain port
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "fifo_uart_defines.vh"

module fifo_serial_interface (
    input wire i_ref_clk,
    input wire i_resetn,
    input wire [`ADDR_W-1:0] i_addr,
    input wire [`DATA_W-1:0] i_wr_data,
    input wire i_wr_stb,
    input wire i_rd_stb,
    output reg [`DATA_W-1:0] o_rd_data,
    input wire i_rxd,
    output wire o_txd,
    input wire i_clear_to_send_n,
    output reg o_request_to_send_n,
    input wire i_ext_clk16,
    output reg o_clk16_tick
);

    localparam [4:0] RX_IDLE = 5'b00001;
    localparam [4:0] RX_START = 5'b00010;
    localparam [4:0] RX_DATA = 5'b00100;
    localparam [4:0] RX_PAR = 5'b01000;
    localparam [4:0] RX_STOP = 5'b10000;
    localparam [1:0] TX_IDLE = 2'b01;
    localparam [1:0] TX_SEND = 2'b10;

    // even or odd parity over seven or eight data bits
    function parity_of;
        input [7:0] data;
        input seven;
        input odd;
        begin
            parity_of = (seven ? ^data[6:0] : ^data) ^ odd;
        end
    endfunction
    // ------
    // registers
    // ------
    reg [`DATA_W-1:0] serial_mode_q;
    reg [`DATA_W-1:0] serial_control_q;
    reg [7:0] baud_div_q;
    reg overrun_flag_q, overrun_seen_q;
    reg framing_err_q, parity_err_q, break_q;
    wire seven_bit = serial_mode_q[`MODE_SEVEN_BIT];
    wire parity_enable = serial_mode_q[`MODE_PARITY_ENABLE];
    wire odd_parity = serial_mode_q[`MODE_ODD_PARITY];
    wire two_stop = serial_mode_q[`MODE_TWO_STOP];
    wire tx_enable = serial_control_q[`CTRL_TX_ENABLE];
    wire receive_enable = serial_control_q[`CTRL_RECEIVE_ENABLE];
    wire flow_enable = serial_control_q[`CTRL_FLOW_ENABLE];
    wire clock_source_select = serial_control_q[`CTRL_CLOCK_SOURCE_SELECT];
    wire wr_mode = i_wr_stb && (i_addr == `OFS_SERIAL_MODE);
    wire wr_ctrl = i_wr_stb && (i_addr == `OFS_SERIAL_CONTROL);
    wire wr_baud = i_wr_stb && (i_addr == `OFS_BAUD_DIV);
    wire wr_tx = i_wr_stb && (i_addr == `OFS_TX_DATA);
    wire wr_stat = i_wr_stb && (i_addr == `OFS_RX_STATUS);
    wire wr_lsr = i_wr_stb && (i_addr == `OFS_LINE_STATUS);
    wire rd_rx = i_rd_stb && (i_addr == `OFS_RECEIVE_FIFO);
    wire rd_lsr = i_rd_stb && (i_addr == `OFS_LINE_STATUS);
    // ------
    // fifos
    // ------
    wire [7:0] tx_fifo_data;
    wire [`FIFO_CNT_W-1:0] tx_count;
    wire tx_full, tx_empty, tx_pop;
    wire [7:0] rx_fifo_data;
    wire [`FIFO_CNT_W-1:0] rx_count;
    wire rx_full, rx_empty, rx_push;
    wire [7:0] rx_push_data;
    uart_fifo tx_fifo_inst (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_push(wr_tx),
        .i_data(i_wr_data[7:0]),
        .i_pop(tx_pop),
        .o_data(tx_fifo_data),
        .o_count(tx_count),
        .o_full(tx_full),
        .o_empty(tx_empty)
    );
    uart_fifo rx_fifo_inst (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_push(rx_push),
        .i_data(rx_push_data),
        .i_pop(rd_rx),
        .o_data(rx_fifo_data),
        .o_count(rx_count),
        .o_full(rx_full),
        .o_empty(rx_empty)
    );
    // ------
    // sixteen-times bit clock
    // ------
    reg [7:0] baud_cnt_q;
    reg ext_clk_q;
    wire baud_tick = (baud_cnt_q >= baud_div_q);
    wire ext_rise = i_ext_clk16 & ~ext_clk_q;
    wire tick = clock_source_select ? ext_rise : baud_tick;
    always @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            baud_cnt_q <= `RST_BAUD_DIV;
            ext_clk_q <= 1'b0;
            o_clk16_tick <= 1'b0;
        end else begin
            ext_clk_q <= i_ext_clk16;
            o_clk16_tick <= tick;
            if (clock_source_select || baud_tick) begin
                baud_cnt_q <= `RST_BAUD_DIV;
            end else begin
                baud_cnt_q <= baud_cnt_q + 1'b1;
            end
        end
    end
    // ------
    // receiver
    // ------
    reg [4:0] rx_state_q;
    reg [3:0] rx_tick_q, rx_bit_q;
    reg [7:0] rx_shift_q;
    reg rx_par_q;
    wire [3:0] data_last = seven_bit ? `DATA_LAST7 : `DATA_LAST8;
    wire [7:0] rx_char = seven_bit ? {1'b0, rx_shift_q[7:1]} : rx_shift_q;
    wire rx_bit_end = tick && (rx_tick_q == `TICK_LAST);
    wire rx_done = (rx_state_q == RX_STOP) && rx_bit_end;
    wire rx_par_bad = parity_enable &&
        (parity_of(rx_char, seven_bit, odd_parity) != rx_par_q);
    always @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            rx_state_q <= RX_IDLE;
            rx_tick_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_shift_q <= 8'h00;
            rx_par_q <= 1'b0;
        end else begin
            if (tick && rx_state_q != RX_IDLE) begin
                rx_tick_q <= rx_tick_q + 1'b1;
            end
            case (rx_state_q)
                RX_IDLE: begin
                    if (tick && receive_enable && !i_rxd) begin
                        rx_state_q <= RX_START;
                        rx_tick_q <= 4'h0;
                    end
                end
                RX_START: begin
                    if (tick && rx_tick_q == `TICK_MID) begin
                        rx_tick_q <= 4'h0;
                        rx_bit_q <= 4'h0;
                        rx_state_q <= i_rxd ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_bit_end) begin
                        rx_shift_q <= {i_rxd, rx_shift_q[7:1]};
                        rx_bit_q <= rx_bit_q + 1'b1;
                        if (rx_bit_q == data_last) begin
                            rx_state_q <= parity_enable ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_bit_end) begin
                        rx_par_q <= i_rxd;
                        rx_state_q <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_bit_end) begin
                        rx_state_q <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state_q <= RX_IDLE;
                end
            endcase
        end
    end
    assign rx_push = rx_done && !overrun_flag_q && !rx_full;
    assign rx_push_data = rx_char;
    // ------
    // error flags
    // ------
    wire overrun_set = rx_done && !overrun_flag_q && rx_full;
    wire overrun_clr = wr_lsr && overrun_seen_q &&
        !i_wr_data[`LSR_OVERRUN];
    wire framing_set = rx_done && !i_rxd;
    wire break_set = framing_set && (rx_char == 8'h00) && !rx_par_q;
    wire parity_set = rx_done && rx_par_bad;
    always @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            overrun_flag_q <= 1'b0;
            overrun_seen_q <= 1'b0;
            framing_err_q <= 1'b0;
            parity_err_q <= 1'b0;
            break_q <= 1'b0;
        end else begin
            if (overrun_set) begin
                overrun_flag_q <= 1'b1;
            end else if (overrun_clr) begin
                overrun_flag_q <= 1'b0;
            end
            if (overrun_set || overrun_clr) begin
                overrun_seen_q <= 1'b0;
            end else if (rd_lsr && overrun_flag_q) begin
                overrun_seen_q <= 1'b1;
            end
            if (framing_set) begin
                framing_err_q <= 1'b1;
            end else if (wr_stat && !i_wr_data[`STAT_FRAMING]) begin
                framing_err_q <= 1'b0;
            end
            if (parity_set) begin
                parity_err_q <= 1'b1;
            end else if (wr_stat && !i_wr_data[`STAT_PARITY]) begin
                parity_err_q <= 1'b0;
            end
            if (break_set) begin
                break_q <= 1'b1;
            end else if (wr_stat && !i_wr_data[`STAT_BREAK]) begin
                break_q <= 1'b0;
            end
        end
    end
    // ------
    // transmitter
    // ------
    reg [1:0] tx_state_q;
    reg [11:0] frame_q, frame_d;
    reg [3:0] tx_bits_q, tx_tick_q, frame_len;
    wire cts_ok = !flow_enable || !i_clear_to_send_n;
    wire tx_start = (tx_state_q == TX_IDLE) && tx_enable && !tx_empty &&
        cts_ok;
    wire tx_par = parity_of(tx_fifo_data, seven_bit, odd_parity);
    assign tx_pop = tx_start;
    assign o_txd = frame_q[0];
    always @* begin
        frame_d = `RST_FRAME;
        frame_d[0] = 1'b0;
        if (seven_bit) begin
            frame_d[7:1] = tx_fifo_data[6:0];
            if (parity_enable) begin
                frame_d[`PAR_IDX7] = tx_par;
            end
        end else begin
            frame_d[8:1] = tx_fifo_data;
            if (parity_enable) begin
                frame_d[`PAR_IDX8] = tx_par;
            end
        end
        frame_len = `FRAME_BASE + data_last + {3'h0, parity_enable} +
            {3'h0, two_stop};
    end
    always @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            tx_state_q <= TX_IDLE;
            frame_q <= `RST_FRAME;
            tx_bits_q <= 4'h0;
            tx_tick_q <= 4'h0;
        end else begin
            case (tx_state_q)
                TX_IDLE: begin
                    if (tx_start) begin
                        frame_q <= frame_d;
                        tx_bits_q <= frame_len;
                        tx_tick_q <= 4'h0;
                        tx_state_q <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (tick) begin
                        tx_tick_q <= tx_tick_q + 1'b1;
                        if (tx_tick_q == `TICK_LAST) begin
                            frame_q <= {1'b1, frame_q[11:1]};
                            tx_bits_q <= tx_bits_q - 1'b1;
                            if (tx_bits_q == 4'h0) begin
                                tx_state_q <= TX_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    tx_state_q <= TX_IDLE;
                end
            endcase
        end
    end
    // ------
    // register writes and read port
    // ------
    always @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            serial_mode_q <= `RST_ZERO16;
            serial_control_q <= `RST_ZERO16;
            baud_div_q <= `RST_BAUD_DIV;
            o_request_to_send_n <= 1'b1;
        end else begin
            if (wr_mode) begin
                serial_mode_q <= i_wr_data & `MODE_MASK;
            end
            if (wr_ctrl) begin
                serial_control_q <= i_wr_data & `CTRL_MASK;
            end
            if (wr_baud) begin
                baud_div_q <= i_wr_data[7:0];
            end
            o_request_to_send_n <= !(flow_enable && !rx_full);
        end
    end
    always @(posedge i_ref_clk) begin
        o_rd_data <= `RST_ZERO16;
        if (i_resetn && i_rd_stb) begin
            if (i_addr == `OFS_SERIAL_MODE) begin
                o_rd_data <= serial_mode_q;
            end else if (i_addr == `OFS_SERIAL_CONTROL) begin
                o_rd_data <= serial_control_q;
            end else if (i_addr == `OFS_BAUD_DIV) begin
                o_rd_data[7:0] <= baud_div_q;
            end else if (i_addr == `OFS_RX_STATUS) begin
                o_rd_data[`STAT_DATA_READY] <= !rx_empty;
                o_rd_data[`STAT_FIFO_FULL] <= rx_full;
                o_rd_data[`STAT_FRAMING] <= framing_err_q;
                o_rd_data[`STAT_PARITY] <= parity_err_q;
                o_rd_data[`STAT_BREAK] <= break_q;
            end else if (i_addr == `OFS_RECEIVE_FIFO) begin
                o_rd_data[7:0] <= rx_empty ? 8'h00 : rx_fifo_data;
            end else if (i_addr == `OFS_FIFO_COUNT) begin
                o_rd_data[`CNT_TX_LSB+4:`CNT_TX_LSB] <= tx_count;
                o_rd_data[`CNT_RX_LSB+4:`CNT_RX_LSB] <= rx_count;
            end else if (i_addr == `OFS_LINE_STATUS) begin
                o_rd_data[`LSR_OVERRUN] <= overrun_flag_q;
            end
        end
    end

endmodule // fifo_serial_interface

`default_nettype wire

// file: logic/uart_fifo.v
// sixteen-entry first-in first-out store with fill count
// assumes push is ignored when full and pop is ignored when empty
`timescale 1ns/100ps
`default_nettype none
`include "fifo_uart_defines.vh"

module uart_fifo (
    input wire i_ref_clk,
    input wire i_resetn,
    input wire i_push,
    input wire [7:0] i_data,
    input wire i_pop,
    output wire [7:0] o_data,
    output wire [`FIFO_CNT_W-1:0] o_count,
    output wire o_full,
    output wire o_empty
);

    reg [7:0] mem [0:`FIFO_DEPTH-1];
    reg [`FIFO_PTR_W-1:0] wr_ptr_q;
    reg [`FIFO_PTR_W-1:0] rd_ptr_q;
    reg [`FIFO_CNT_W-1:0] count_q;
    wire do_push;
    wire do_pop;

    assign o_full = (count_q == `FIFO_FULL_COUNT);
    assign o_empty = (count_q == `FIFO_EMPTY_COUNT);
    assign do_push = i_push & ~o_full;
    assign do_pop = i_pop & ~o_empty;
    assign o_data = mem[rd_ptr_q];
    assign o_count = count_q;

    // ------
    // storage and pointers
    // ------
    always @(posedge i_ref_clk) begin
        if (do_push) begin
            mem[wr_ptr_q] <= i_data;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            wr_ptr_q <= {`FIFO_PTR_W{1'b0}};
            rd_ptr_q <= {`FIFO_PTR_W{1'b0}};
            count_q <= `FIFO_EMPTY_COUNT;
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_q <= count_q + 1'b1;
            end else if (do_pop && !do_push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule // uart_fifo

`default_nettype wire

// file: pkg/fifo_uart_defines.vh
// named constants of the fifo serial interface: offsets, fields, counts
// assumes inclusion by bare name from the logic files
`ifndef FIFO_UART_DEFINES_VH
`define FIFO_UART_DEFINES_VH

// register offsets
`define ADDR_W 5
`define DATA_W 16
`define OFS_SERIAL_MODE 5'h00
`define OFS_SERIAL_CONTROL 5'h04
`define OFS_BAUD_DIV 5'h08
`define OFS_TX_DATA 5'h0c
`define OFS_RX_STATUS 5'h10
`define OFS_RECEIVE_FIFO 5'h14
`define OFS_FIFO_COUNT 5'h18
`define OFS_LINE_STATUS 5'h1c

// serial_mode fields
`define MODE_SEVEN_BIT 6
`define MODE_PARITY_ENABLE 5
`define MODE_ODD_PARITY 4
`define MODE_TWO_STOP 3
`define MODE_MASK 16'h0078

// serial_control fields
`define CTRL_TX_ENABLE 5
`define CTRL_RECEIVE_ENABLE 4
`define CTRL_FLOW_ENABLE 3
`define CTRL_CLOCK_SOURCE_SELECT 1
`define CTRL_MASK 16'h003a

// rx status fields
`define STAT_DATA_READY 0
`define STAT_FIFO_FULL 1
`define STAT_FRAMING 2
`define STAT_PARITY 3
`define STAT_BREAK 4

// line_status fields
`define LSR_OVERRUN 0

// fifo counts field positions
`define CNT_TX_LSB 8
`define CNT_RX_LSB 0

// reset values
`define RST_ZERO16 16'h0000
`define RST_BAUD_DIV 8'h00
`define RST_FRAME 12'hfff

// fifo geometry
`define FIFO_DEPTH 16
`define FIFO_PTR_W 4
`define FIFO_CNT_W 5
`define FIFO_FULL_COUNT 5'h10
`define FIFO_EMPTY_COUNT 5'h00

// sampling at sixteen ticks per bit
`define TICK_MID 4'h7
`define TICK_LAST 4'hf
`define DATA_LAST8 4'h7
`define DATA_LAST7 4'h6
`define FRAME_BASE 4'h2
`define PAR_IDX8 4'h9
`define PAR_IDX7 4'h8

`endif

// file: tb/fifo_serial_interface_monitor.sv
// checker of the fifo serial interface top-level ports
// assumes one clock, synchronous active-low reset, header register map
`timescale 1ns/100ps
`default_nettype none
`include "fifo_uart_defines.vh"

module fifo_serial_interface_monitor (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [`ADDR_W-1:0] i_addr,
    input wire logic [`DATA_W-1:0] i_wr_data,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    input wire logic [`DATA_W-1:0] o_rd_data,
    input wire logic i_rxd,
    input wire logic o_txd,
    input wire logic i_clear_to_send_n,
    input wire logic o_request_to_send_n,
    input wire logic i_ext_clk16,
    input wire logic o_clk16_tick
);
    // ------
    // shadows
    // ------
    logic flow_q, src_q, rd_ls_q, ovr_q;
    logic [7:0] div_q;
    logic [3:0] settle_q, low_q;
    wire wr_ctl = i_wr_stb && i_addr == `OFS_SERIAL_CONTROL;
    wire wr_div = i_wr_stb && i_addr == `OFS_BAUD_DIV;
    wire wr_ls = i_wr_stb && i_addr == `OFS_LINE_STATUS;
    wire rd_ls = i_rd_stb && i_addr == `OFS_LINE_STATUS;
    wire rd_cnt = i_rd_stb && i_addr == `OFS_FIFO_COUNT;
    wire int_ok = !src_q && div_q == 8'h00 && settle_q > 4'h3;
    wire ext_ok = src_q && settle_q > 4'h3;

    always @(posedge i_ref_clk) begin
        rd_ls_q <= rd_ls && i_resetn;
        if (!i_resetn || (wr_ls && !i_wr_data[0])) begin
            ovr_q <= 1'b0;
        end else if (rd_ls_q && o_rd_data[0]) begin
            ovr_q <= 1'b1;
        end
        if (!i_resetn) begin
            flow_q <= 1'b0;
            src_q <= 1'b0;
            div_q <= 8'h00;
            settle_q <= 4'h0;
            low_q <= 4'h0;
        end else begin
            if (wr_ctl) begin
                flow_q <= i_wr_data[`CTRL_FLOW_ENABLE];
                src_q <= i_wr_data[`CTRL_CLOCK_SOURCE_SELECT];
            end
            if (wr_div) begin
                div_q <= i_wr_data[7:0];
            end
            if (wr_ctl || wr_div) begin
                settle_q <= 4'h0;
            end else if (settle_q != 4'hf) begin
                settle_q <= settle_q + 4'h1;
            end
            low_q <= i_ext_clk16 ? 4'h0 : low_q + {3'h0, low_q != 4'hf};
        end
    end

    // ------
    // checks
    // ------
    default clocking mon_cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);

    ls_rsvd_a: assert property (
        rd_ls |=> o_rd_data[15:1] == 15'h0000)
        else $error("line status upper bits not zero");
    cnt_range_a: assert property (
        rd_cnt |=> o_rd_data[4:0] <= 5'h10 && o_rd_data[12:8] <= 5'h10)
        else $error("fifo count out of range");
    rts_flow_a: assert property (
        !flow_q && $past(!flow_q) |-> o_request_to_send_n)
        else $error("request to send low without flow control");
    int_tick_a: assert property (
        int_ok |-> o_clk16_tick)
        else $error("internal tick missing");
    ext_tick_a: assert property (
        ext_ok && $rose(i_ext_clk16) |-> ##[1:3] o_clk16_tick)
        else $error("external edge gave no tick");
    ext_idle_a: assert property (
        ext_ok && low_q > 4'h3 |-> !o_clk16_tick)
        else $error("tick without external edge");
    start_len_a: assert property (
        int_ok && $fell(o_txd) |-> (!o_txd) [*8] ##1 (!o_txd) [*8])
        else $error("low bit shorter than sixteen ticks");
    ovr_hold_a: assert property (
        rd_ls_q && ovr_q |-> o_rd_data[0])
        else $error("overrun flag lost without zero write");

    cover property (rd_ls_q && o_rd_data[0]);
    cover property (ext_ok && $rose(i_ext_clk16));
    cover property (int_ok && $fell(o_txd));
endmodule // fifo_serial_interface_monitor

bind fifo_serial_interface fifo_serial_interface_monitor u_monitor (
    .i_ref_clk,
    .i_resetn,
    .i_addr,
    .i_wr_data,
    .i_wr_stb,
    .i_rd_stb,
    .o_rd_data,
    .i_rxd,
    .o_txd,
    .i_clear_to_send_n,
    .o_request_to_send_n,
    .i_ext_clk16,
    .o_clk16_tick
);
`default_nettype wire

// file: tb/fifo_serial_interface_tb.sv
// self-checking bench of the fifo serial interface
// assumes the peer model on the serial side and the header register map
`timescale 1ns/100ps
`default_nettype none
`include "fifo_uart_defines.vh"

module fifo_serial_interface_tb;
    logic i_ref_clk, i_resetn, i_wr_stb, i_rd_stb, i_rxd, o_txd;
    logic i_clear_to_send_n, o_request_to_send_n, i_ext_clk16;
    logic o_clk16_tick;
    logic [`ADDR_W-1:0] i_addr;
    logic [`DATA_W-1:0] i_wr_data, o_rd_data, w;
    logic [15:0] fmt_tab [4] = '{16'h0000, 16'h0008, 16'h0020, 16'h0078};
    int fails, n_tests, cyc, ticks;

    fifo_serial_interface u_fifo_serial_interface (
        .i_ref_clk, .i_resetn, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb,
        .o_rd_data, .i_rxd, .o_txd, .i_clear_to_send_n,
        .o_request_to_send_n, .i_ext_clk16, .o_clk16_tick
    );
    serial_peer_model u_serial_peer_model (
        .i_ref_clk(i_ref_clk),
        .i_txd(o_txd),
        .o_rxd(i_rxd),
        .o_clear_to_send_n(i_clear_to_send_n),
        .o_ext_clk16(i_ext_clk16)
    );

    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (o_clk16_tick === 1'b1) begin
            ticks <= ticks + 1;
        end
        if (cyc == 20000) begin
            fails++;
            report_and_stop;
        end
    end

    // ------
    // helpers
    // ------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wr_data <= d;
        i_wr_stb <= 1'b1;
        @(posedge i_ref_clk);
        i_wr_stb <= 1'b0;
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd_stb <= 1'b1;
        @(posedge i_ref_clk);
        i_rd_stb <= 1'b0;
        #1 chk(o_rd_data, exp);
    endtask
    task automatic send8(input logic [7:0] d);
        u_serial_peer_model.send_char(d, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    endtask

    // ------
    // scenarios
    // ------
    task automatic t_reset;
        chk({15'h0000, o_request_to_send_n}, 16'h0001);
        rdchk(`OFS_LINE_STATUS, 16'h0000);
        rdchk(`OFS_FIFO_COUNT, 16'h0000);
        rdchk(5'h02, 16'h0000);
    endtask
    task automatic t_clock;
        wr(`OFS_SERIAL_CONTROL, 16'h0002);
        repeat (8) @(posedge i_ref_clk);
        #1 ticks = 0;
        u_serial_peer_model.run_ext(10);
        repeat (6) @(posedge i_ref_clk);
        #1 chk(ticks[15:0], 16'h000a);
        wr(`OFS_SERIAL_CONTROL, 16'h0000);
        wr(`OFS_BAUD_DIV, 16'h0003);
        repeat (8) @(posedge i_ref_clk);
        #1 ticks = 0;
        repeat (40) @(posedge i_ref_clk);
        #1 chk(ticks[15:0], 16'h000a);
        wr(`OFS_BAUD_DIV, 16'h0000);
    endtask
    task automatic t_format;
        logic [15:0] m;
        logic [7:0] d;
        logic p;
        wr(`OFS_SERIAL_CONTROL, 16'h0020);
        for (int i = 0; i < 4; i++) begin
            m = fmt_tab[i];
            d = m[6] ? 8'h26 : 8'ha6;
            p = m[5] & (^d ^ m[4]);
            wr(`OFS_SERIAL_MODE, m);
            wr(`OFS_TX_DATA, 16'h00a6);
            wr(`OFS_TX_DATA, 16'h0000);
            u_serial_peer_model.get_char(m[6] ? 7 : 8, m[5], w);
            chk(w, {5'h00, m[3], 1'b1, p, d});
            repeat (220) @(posedge i_ref_clk);
        end
    endtask
    task automatic t_errors;
        wr(`OFS_SERIAL_MODE, 16'h0020);
        wr(`OFS_SERIAL_CONTROL, 16'h0010);
        u_serial_peer_model.send_char(8'h55, 8, 1'b1, 1'b0, 1'b1, 1'b1);
        rdchk(`OFS_RX_STATUS, 16'h0009);
        u_serial_peer_model.send_char(8'h0f, 8, 1'b1, 1'b0, 1'b0, 1'b0);
        rdchk(`OFS_RX_STATUS, 16'h000d);
        u_serial_peer_model.send_char(8'h00, 8, 1'b1, 1'b0, 1'b0, 1'b0);
        rdchk(`OFS_RX_STATUS, 16'h001d);
        wr(`OFS_RX_STATUS, 16'h0000);
        rdchk(`OFS_RX_STATUS, 16'h0001);
        rdchk(`OFS_FIFO_COUNT, 16'h0003);
        rdchk(`OFS_RECEIVE_FIFO, 16'h0055);
        rdchk(`OFS_RECEIVE_FIFO, 16'h000f);
        rdchk(`OFS_RECEIVE_FIFO, 16'h0000);
    endtask
    task automatic t_overrun;
        wr(`OFS_SERIAL_MODE, 16'h0000);
        wr(`OFS_SERIAL_CONTROL, 16'h0018);
        repeat (2) @(posedge i_ref_clk);
        #1 chk({15'h0000, o_request_to_send_n}, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            send8(8'h30 + i[7:0]);
        end
        rdchk(`OFS_FIFO_COUNT, 16'h0010);
        rdchk(`OFS_RX_STATUS, 16'h0003);
        chk({15'h0000, o_request_to_send_n}, 16'h0001);
        rdchk(`OFS_LINE_STATUS, 16'h0000);
        send8(8'h40);
        rdchk(`OFS_LINE_STATUS, 16'h0001);
        wr(`OFS_SERIAL_CONTROL, 16'h0008);
        rdchk(`OFS_LINE_STATUS, 16'h0001);
        wr(`OFS_LINE_STATUS, 16'h0001);
        rdchk(`OFS_LINE_STATUS, 16'h0001);
        wr(`OFS_SERIAL_CONTROL, 16'h0018);
        rdchk(`OFS_RECEIVE_FIFO, 16'h0030);
        send8(8'h41);
        rdchk(`OFS_FIFO_COUNT, 16'h000f);
        wr(`OFS_LINE_STATUS, 16'h0000);
        rdchk(`OFS_LINE_STATUS, 16'h0000);
        send8(8'h99);
        for (int i = 1; i < 16; i++) begin
            rdchk(`OFS_RECEIVE_FIFO, 16'h0030 + i[15:0]);
        end
        rdchk(`OFS_RECEIVE_FIFO, 16'h0099);
        rdchk(`OFS_FIFO_COUNT, 16'h0000);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        i_resetn = 1'b0;
        i_addr = 5'h00;
        i_wr_data = 16'h0000;
        i_wr_stb = 1'b0;
        i_rd_stb = 1'b0;
        repeat (12) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        t_reset;
        t_clock;
        t_format;
        t_errors;
        t_overrun;
        report_and_stop;
    end
endmodule // fifo_serial_interface_tb
`default_nettype wire

// file: tb/serial_peer_model.sv
// remote serial device: drives rxd, cts and the external 16x clock
// assumes sixteen reference clocks per bit, tasks called by the bench
`timescale 1ns/100ps
`default_nettype none

module serial_peer_model (
    input wire logic i_ref_clk,
    input wire logic i_txd,
    output logic o_rxd,
    output logic o_clear_to_send_n,
    output logic o_ext_clk16
);
    initial begin
        o_rxd = 1'b1;
        o_clear_to_send_n = 1'b0;
        o_ext_clk16 = 1'b0;
    end

    task automatic put_bit(input logic b);
        @(posedge i_ref_clk);
        o_rxd <= b;
        repeat (15) @(posedge i_ref_clk);
    endtask

    // own start bit per character, then one idle bit
    task automatic send_char(input logic [7:0] d, input int n,
        input logic par_en, input logic odd, input logic bad,
        input logic stp);
        logic p;
        p = odd ^ bad;
        put_bit(1'b0);
        for (int i = 0; i < n; i++) begin
            put_bit(d[i]);
            p = p ^ d[i];
        end
        if (par_en) begin
            put_bit(p);
        end
        put_bit(stp);
        put_bit(1'b1);
    endtask

    // returns {stop2 slot, stop1, parity, data}
    task automatic get_char(input int n, input logic par_en,
        output logic [15:0] w);
        int k;
        k = 0;
        w = 16'h0000;
        while (i_txd !== 1'b0 && k < 4000) begin
            @(posedge i_ref_clk);
            k++;
        end
        repeat (8) @(posedge i_ref_clk);
        for (int i = 0; i < n; i++) begin
            repeat (16) @(posedge i_ref_clk);
            w[i] = i_txd;
        end
        for (int i = par_en ? 8 : 9; i < 11; i++) begin
            repeat (16) @(posedge i_ref_clk);
            w[i] = i_txd;
        end
    endtask

    // external clock, one rising edge every two reference clocks, n edges then held low
    task automatic run_ext(input int n);
        repeat (n) begin
            @(posedge i_ref_clk);
            o_ext_clk16 <= 1'b1;
            @(posedge i_ref_clk);
            o_ext_clk16 <= 1'b0;
        end
    endtask
endmodule // serial_peer_model
`default_nettype wire
